// *** rtl/dvcfe_defs.vh ***
// Purpose: Constants for the violation counter and force-error block
// Assumes: Byte-wide register port, 8-bit addresses
// Notes:   Definitions only
`ifndef DVCFE_DEFS_VH
`define DVCFE_DEFS_VH
`define DVCFE_ADDR_CNT_LO   8'h12
`define DVCFE_ADDR_CNT_HI   8'h13
`define DVCFE_ADDR_CTRL     8'h14
`define DVCFE_CTRL_RESET    8'h00
`define DVCFE_BIT_CNT_EN    0
`define DVCFE_BIT_ZERO_EN   1
`define DVCFE_BIT_TEST      2
`define DVCFE_BIT_INJ_CP    3
`define DVCFE_BIT_INJ_PP    4
`define DVCFE_BIT_INJ_FEBE  5
`define DVCFE_BIT_TX_STUFF  6
`define DVCFE_BIT_RX_STUFF  7
`define DVCFE_CNT_W         16
`define DVCFE_CNT_MAX       16'hFFFF
`endif

// *** rtl/dvcfe_sync.v ***
// Purpose: Three-stage synchroniser with agreement filter for a pin input
// Assumes: Input is asynchronous to i_clk
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
module dvcfe_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_async,
  output reg  o_sync
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_q   <= RST_VAL;
      s2_q   <= RST_VAL;
      s3_q   <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_sync <= s3_q;
      end
    end
  end
endmodule

// *** rtl/dvcfe_top.v ***
// Purpose: Violation/zero-run counter with two banks, stuff gap and force-error control
// Assumes: i_clk is the receive line clock; byte bus with address latch strobe
// Notes:   Frame timing is external; block issues one-cycle inject requests
// Functional notes
// - Sixteen-bit saturating counter increments on each clock with violation input high.
// - With zero-run enable set, also count cycles where zero-run input is low.
// - Line inputs sampled on the rising receive line clock edge.
// - Two banks; low-byte read swaps banks and returns frozen low byte.
// - Every falling latch strobe with low-byte address selected swaps banks.
// - Receive stuff gap enable passes stuff slot in M13 serial mode when two of three C-bits set.
// - Transmit stuff gap enable passes stuff slots in M13 serial mode.
// - Software block-error inject zeroes C10-C12 next frame in C-bit mode.
// - Software P-parity inject inverts both P-bits in next frame.
// - Software C-parity inject inverts C7-C9 next frame in C-bit mode.
// - One error per zero-to-one transition of each force bit.
// - Counter enable set: force pins ignored, control bits 3-5 inject instead.
// - Counter enable set: C-force pin is violation input, P-force pin zero-run input.
`timescale 1ns/1ps
`include "dvcfe_defs.vh"
module dvcfe_top #(
  parameter CNT_W = `DVCFE_CNT_W
) (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire [7:0]   i_addr,
  input  wire         i_ale,
  input  wire         i_rd,
  input  wire         i_wr,
  input  wire [7:0]   i_wdata,
  output reg  [7:0]   o_rdata,
  output wire         o_rdata_oe_n,
  input  wire         i_line_violation_in,
  input  wire         i_zero_run_in_n,
  input  wire         i_force_cp_pin,
  input  wire         i_force_pp_pin,
  input  wire         i_force_febe_pin,
  input  wire         i_m13_mode,
  input  wire         i_serial_mode,
  input  wire         i_cbit_parity_mode,
  input  wire         i_rx_payload_slot,
  input  wire         i_rx_stuff_slot,
  input  wire [2:0]   i_rx_cbits,
  input  wire         i_tx_payload_slot,
  input  wire         i_tx_stuff_slot,
  input  wire         i_frame_start,
  output reg          o_rx_gapped_clock_n,
  output reg          o_tx_gapped_clock_n,
  output reg          o_inject_block_error,
  output reg          o_inject_p_parity_error,
  output reg          o_inject_c_parity_error
);
  reg  [7:0]       ctrl_q;
  reg  [CNT_W-1:0] bank0_q;
  reg  [CNT_W-1:0] bank1_q;
  reg              sel_q;
  reg  [7:0]       hi_hold_q;
  reg              rd_q;
  reg              ale_q;
  reg  [2:0]       sw_prev_q;
  reg  [2:0]       pin_prev_q;
  reg  [2:0]       pend_q;
  wire             vio_s;
  wire             zero_n_s;
  wire             fcp_s;
  wire             fpp_s;
  wire             ffebe_s;
  wire             cnt_en;
  wire             lo_sel;
  wire             hi_sel;
  wire             rd_rise;
  wire             ale_fall;
  wire             swap;
  wire             clr;
  wire             inc;
  wire             cnt_sel;
  wire [2:0]       sw_bits;
  wire [2:0]       sw_rise;
  wire [2:0]       pin_bits;
  wire [2:0]       src_bits;
  wire             c_ok;
  wire             ms_mode;
  wire             maj;

  dvcfe_sync u_sync_vio (.i_clk(i_clk), .i_rst_n(i_rst_n),
                         .i_async(i_line_violation_in), .o_sync(vio_s));
  dvcfe_sync #(.RST_VAL(1'b1)) u_sync_zero (.i_clk(i_clk), .i_rst_n(i_rst_n),
                         .i_async(i_zero_run_in_n), .o_sync(zero_n_s));
  dvcfe_sync u_sync_fcp (.i_clk(i_clk), .i_rst_n(i_rst_n),
                         .i_async(i_force_cp_pin), .o_sync(fcp_s));
  dvcfe_sync u_sync_fpp (.i_clk(i_clk), .i_rst_n(i_rst_n),
                         .i_async(i_force_pp_pin), .o_sync(fpp_s));
  dvcfe_sync u_sync_febe (.i_clk(i_clk), .i_rst_n(i_rst_n),
                          .i_async(i_force_febe_pin), .o_sync(ffebe_s));

  assign cnt_en   = ctrl_q[`DVCFE_BIT_CNT_EN];
  assign lo_sel   = (i_addr == `DVCFE_ADDR_CNT_LO);
  assign hi_sel   = (i_addr == `DVCFE_ADDR_CNT_HI);
  assign rd_rise  = i_rd & ~rd_q;
  assign ale_fall = ale_q & ~i_ale;
  assign swap     = (rd_rise & lo_sel) | (ale_fall & lo_sel);
  assign clr      = rd_rise & hi_sel;
  // Bank that counts after this edge, so an event at a swap is not lost
  assign cnt_sel  = swap ? ~sel_q : sel_q;

  // Counter inputs come from force pins only when enabled
  assign inc = cnt_en & (fcp_s |
               (ctrl_q[`DVCFE_BIT_ZERO_EN] & ~fpp_s));
  // Unused inputs kept sampled for the pin-driven counting variant
  wire unused_ok = vio_s | zero_n_s;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      rd_q  <= 1'b0;
      ale_q <= 1'b0;
    end else begin
      rd_q  <= i_rd;
      ale_q <= i_ale;
    end
  end

  // Bank 0 counts when cnt_sel is 0, bank 1 otherwise
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      bank0_q   <= {CNT_W{1'b0}};
      bank1_q   <= {CNT_W{1'b0}};
      sel_q     <= 1'b0;
      hi_hold_q <= 8'h00;
    end else begin
      if (swap) begin
        sel_q     <= ~sel_q;
        hi_hold_q <= frozen_next_hi(sel_q, bank0_q, bank1_q);
      end
      if (!cnt_sel) begin
        if (inc && bank0_q != `DVCFE_CNT_MAX) begin
          bank0_q <= bank0_q + 1'b1;
        end
        if (clr) begin
          bank1_q <= {CNT_W{1'b0}};
        end
      end else begin
        if (inc && bank1_q != `DVCFE_CNT_MAX) begin
          bank1_q <= bank1_q + 1'b1;
        end
        if (clr) begin
          bank0_q <= {CNT_W{1'b0}};
        end
      end
    end
  end

  // Upper byte of the bank that becomes frozen at a swap
  function [7:0] frozen_next_hi;
    input              s;
    input [CNT_W-1:0]  b0;
    input [CNT_W-1:0]  b1;
    begin
      frozen_next_hi = s ? b1[CNT_W-1:CNT_W-8] : b0[CNT_W-1:CNT_W-8];
    end
  endfunction

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= `DVCFE_CTRL_RESET;
    end else if (i_wr && i_addr == `DVCFE_ADDR_CTRL) begin
      ctrl_q <= i_wdata;
    end
  end

  // Low byte taken from the bank being frozen by this read
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (rd_rise) begin
      if (lo_sel) begin
        o_rdata <= sel_q ? bank1_q[7:0] : bank0_q[7:0];
      end else if (hi_sel) begin
        o_rdata <= hi_hold_q;
      end else if (i_addr == `DVCFE_ADDR_CTRL) begin
        o_rdata <= ctrl_q;
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end
  assign o_rdata_oe_n = ~(i_rd & (lo_sel | hi_sel | (i_addr == `DVCFE_ADDR_CTRL)));

  // Force-error sources: bits {febe, pp, cp}
  assign sw_bits  = {ctrl_q[`DVCFE_BIT_INJ_FEBE], ctrl_q[`DVCFE_BIT_INJ_PP],
                     ctrl_q[`DVCFE_BIT_INJ_CP]};
  assign sw_rise  = sw_bits & ~sw_prev_q;
  assign pin_bits = {ffebe_s, fpp_s, fcp_s};
  // Separate edge history per source: no false or lost edge when the enable flips
  assign src_bits = cnt_en ? sw_rise : (pin_bits & ~pin_prev_q);
  assign c_ok     = i_cbit_parity_mode;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      sw_prev_q               <= 3'h0;
      pin_prev_q              <= 3'h0;
      pend_q                  <= 3'h0;
      o_inject_block_error    <= 1'b0;
      o_inject_p_parity_error <= 1'b0;
      o_inject_c_parity_error <= 1'b0;
    end else begin
      sw_prev_q  <= sw_bits;
      pin_prev_q <= pin_bits;
      if (i_frame_start) begin
        o_inject_block_error    <= pend_q[2] & c_ok;
        o_inject_p_parity_error <= pend_q[1];
        o_inject_c_parity_error <= pend_q[0] & c_ok;
        pend_q                  <= src_bits;
      end else begin
        o_inject_block_error    <= 1'b0;
        o_inject_p_parity_error <= 1'b0;
        o_inject_c_parity_error <= 1'b0;
        pend_q                  <= pend_q | src_bits;
      end
    end
  end

  assign ms_mode = i_m13_mode & i_serial_mode;
  assign maj = (i_rx_cbits[0] & i_rx_cbits[1]) | (i_rx_cbits[0] & i_rx_cbits[2]) |
               (i_rx_cbits[1] & i_rx_cbits[2]);

  // Gapped clocks are active low: low marks a passed bit slot
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rx_gapped_clock_n <= 1'b1;
      o_tx_gapped_clock_n <= 1'b1;
    end else begin
      o_rx_gapped_clock_n <= ~(i_rx_payload_slot |
        (i_rx_stuff_slot & ctrl_q[`DVCFE_BIT_RX_STUFF] & ms_mode & maj));
      o_tx_gapped_clock_n <= ~(i_tx_payload_slot |
        (i_tx_stuff_slot & ctrl_q[`DVCFE_BIT_TX_STUFF] & ms_mode));
    end
  end
endmodule

// *** testbench/dvcfe_asserts.sv ***
// Purpose: Port-level checks of the violation counter and force-error block
// Assumes: One clock domain, sync active-low reset
// Notes:   Shadows the control register from bus writes
`timescale 1ns/1ps
module dvcfe_asserts (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_rd,
  input wire logic       i_wr,
  input wire logic       i_m13_mode,
  input wire logic       i_serial_mode,
  input wire logic       i_cbit_parity_mode,
  input wire logic       i_rx_payload_slot,
  input wire logic       i_rx_stuff_slot,
  input wire logic       i_tx_stuff_slot,
  input wire logic       i_frame_start,
  input wire logic       o_rdata_oe_n,
  input wire logic       o_rx_gapped_clock_n,
  input wire logic       o_tx_gapped_clock_n,
  input wire logic       o_inject_block_error,
  input wire logic       o_inject_p_parity_error,
  input wire logic       o_inject_c_parity_error,
  input wire logic [2:0] i_rx_cbits,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata
);
  logic [7:0] ctrl_q = 8'h00;
  logic       mode;
  logic       maj;
  assign mode = i_m13_mode && i_serial_mode;
  assign maj  = (i_rx_cbits[0] & i_rx_cbits[1]) | (i_rx_cbits[2] & (i_rx_cbits[0] | i_rx_cbits[1]));
  // Shadow of the control register
  always @(posedge i_clk) begin
    if (!i_rst_n) ctrl_q <= 8'h00;
    else if (i_wr && i_addr == 8'h14) ctrl_q <= i_wdata;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_ctrl_readback:
    assert property ($rose(i_rd) && i_addr == 8'h14 |=> o_rdata == $past(ctrl_q)) else $error("ctrl");
  chk_oe_idle:
    assert property (!i_rd |-> o_rdata_oe_n) else $error("oe idle");
  chk_rx_stuff_pass:
    assert property (i_rx_stuff_slot && ctrl_q[7] && mode && maj |=> !o_rx_gapped_clock_n) else $error("rx pass");
  chk_rx_stuff_block:
    assert property (i_rx_stuff_slot && !i_rx_payload_slot && !(ctrl_q[7] && mode && maj)
      |=> o_rx_gapped_clock_n) else $error("rx block");
  chk_tx_stuff_pass:
    assert property (i_tx_stuff_slot && ctrl_q[6] && mode |=> !o_tx_gapped_clock_n) else $error("tx");
  chk_febe_frame:
    assert property (o_inject_block_error |-> $past(i_frame_start) && $past(i_cbit_parity_mode)) else $error("febe");
  chk_pp_frame:
    assert property (o_inject_p_parity_error |-> $past(i_frame_start)) else $error("pp");
  chk_cp_frame:
    assert property (o_inject_c_parity_error |-> $past(i_frame_start) && $past(i_cbit_parity_mode)) else $error("cp");
  chk_pp_single:
    assert property (o_inject_p_parity_error |=> !o_inject_p_parity_error) else $error("pp twice");
  cover property (o_inject_p_parity_error);
  cover property (o_inject_block_error);
  cover property ($rose(i_rd) && i_addr == 8'h12);
  cover property (i_rx_stuff_slot && ctrl_q[7] && mode && maj);
endmodule

// *** testbench/dvcfe_line_model.sv ***
// Purpose: Line interface model driving the repurposed force pins
// Assumes: Indications change just after the rising edge
// Notes:   Violation run first, then zero-run event run
`timescale 1ns/1ps
module dvcfe_line_model (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [16:0] i_cv_len,
  input  wire logic [7:0]  i_zr_len,
  output wire logic        o_cv,
  output wire logic        o_zero_n,
  output wire logic        o_busy
);
  logic [16:0] cv_q = 17'h00000;
  logic [7:0]  zr_q = 8'h00;
  always @(posedge i_clk) begin
    if (i_go) begin
      cv_q <= i_cv_len;
      zr_q <= i_zr_len;
    end else if (cv_q != 0) cv_q <= cv_q - 1;
    else if (zr_q != 0) zr_q <= zr_q - 1;
  end
  assign o_cv     = cv_q != 0;
  assign o_zero_n = !(cv_q == 0 && zr_q != 0);
  assign o_busy   = cv_q != 0 || zr_q != 0;
endmodule

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the violation counter block
// Assumes: Reads answer one cycle after rd rises
// Notes:   Timing inputs randomised every cycle
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected %0t got %h exp %h", $time, a, e); end end
module testbench;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_ale = 1'b0, i_rd = 1'b0, i_wr = 1'b0;
  logic i_force_febe_pin = 1'b0, go = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, exp_v, zl = 8'h00;
  logic [16:0] cl = 17'h00000;
  logic [12:0] rnd = 13'h0000;
  logic o_rdata_oe_n, o_rx_gapped_clock_n, o_tx_gapped_clock_n, cv, zn, busy;
  logic o_inject_block_error, o_inject_p_parity_error, o_inject_c_parity_error;
  logic [7:0] exp_q[$];
  int seed = 59, n_mismatch = 0, checks_done = 0, hi = 0, np = 0, nb = 0, nc = 0, n, k;
  dvcfe_top dut_u (.*, .i_line_violation_in(rnd[0]), .i_zero_run_in_n(rnd[1]),
    .i_force_cp_pin(cv), .i_force_pp_pin(zn), .i_m13_mode(rnd[2]), .i_serial_mode(rnd[3]),
    .i_cbit_parity_mode(rnd[4]), .i_rx_payload_slot(rnd[5]), .i_rx_stuff_slot(rnd[6]),
    .i_rx_cbits(rnd[9:7]), .i_tx_payload_slot(rnd[10]), .i_tx_stuff_slot(rnd[11]),
    .i_frame_start(rnd[12]));
  dvcfe_line_model line_u (.i_clk(i_clk), .i_go(go), .i_cv_len(cl), .i_zr_len(zl),
    .o_cv(cv), .o_zero_n(zn), .o_busy(busy));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) rnd <= $random(seed);
  always @(negedge i_clk) begin
    if (o_inject_p_parity_error === 1'b1) np++;
    if (o_inject_block_error === 1'b1) nb++;
    if (o_inject_c_parity_error === 1'b1) nc++;
    if (i_rd && hi == 1) begin
      exp_v = exp_q.pop_front();
      `CHK(o_rdata, exp_v)
    end
    hi = i_rd ? hi + 1 : 0;
  end
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  task ale(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_ale <= 1'b1;
    @(posedge i_clk);
    i_ale <= 1'b0;
    @(posedge i_clk);
  endtask
  task wr(input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= 8'h14;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task line(input logic [16:0] c, input logic [7:0] z);
    @(posedge i_clk);
    cl <= c;
    zl <= z;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    for (k = 0; k < 70000 && busy; k++) @(posedge i_clk);
    repeat (8) @(posedge i_clk);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(100000 * 50);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h00);
    wr(8'hC1);
    n = 3 + ($random(seed) & 15);
    line(n[16:0], 8'h05);
    rd(8'h12, n[7:0]);
    rd(8'h13, 8'h00);
    wr(8'hC3);
    line(17'h00000, n[7:0] + 8'h02);
    rd(8'h12, n[7:0] + 8'h02);
    rd(8'h13, 8'h00);
    wr(8'hC1);
    line(17'h10010, 8'h00);
    rd(8'h12, 8'hFF);
    rd(8'h13, 8'hFF);
    line(17'h00005, 8'h00);
    ale(8'h12);
    line(17'h00002, 8'h00);
    rd(8'h12, 8'h02);
    rd(8'h13, 8'h00);
    np = 0;
    wr(8'hD1);
    repeat (20) @(posedge i_clk);
    wr(8'hC1);
    wr(8'hF9);
    repeat (20) @(posedge i_clk);
    wr(8'h10);
    line(17'h00000, 8'h02);
    line(17'h00003, 8'h00);
    @(posedge i_clk);
    i_force_febe_pin <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_force_febe_pin <= 1'b0;
    repeat (20) @(posedge i_clk);
    `CHK(np, 3)
    `CHK(nb <= 2, 1'b1)
    `CHK(nc <= 2, 1'b1)
    print_verdict;
  end
endmodule
bind dvcfe_top dvcfe_asserts chk_u (.i_clk, .i_rst_n, .i_rd, .i_wr, .i_m13_mode,
  .i_serial_mode, .i_cbit_parity_mode, .i_rx_payload_slot, .i_rx_stuff_slot,
  .i_tx_stuff_slot, .i_frame_start, .o_rdata_oe_n, .o_rx_gapped_clock_n,
  .o_tx_gapped_clock_n, .o_inject_block_error, .o_inject_p_parity_error,
  .o_inject_c_parity_error, .i_rx_cbits, .i_addr, .i_wdata, .o_rdata);
